// ==== design/cfgsup_params.svh ====
// Purpose: Constants for the configuration loader and backplane supervisor
// Assumes: Configuration words arrive one per beat with a word offset
// Notes: Offsets are word offsets within the configuration area
// Behaviour
// - After power-up wait for configuration; no serial traffic until received.
// - After configuration and init, run only the ports marked enabled.
// - Warm or cold boot refetches configuration; changes apply only by reload.
// - Boot requests come from the host program or the local debug port.
// - Zero failure threshold keeps ports running despite backplane failures.
// - Nonzero threshold: count successive failures, report and stop at threshold.
// - After failure shutdown, resume on the first successful backplane transfer.
// - Host files: config 300 words, read data 500, write data 500, contiguous.
// - Port receive data goes to read area; write area data is transmitted.
// - Threshold is first config parameter; port parameters at offsets 1 to 46.
// - Threshold at offset 0, values 1 to 65535 stop after that many failures.
// - Port enable word 0 disables the port, 1 enables it.
`ifndef CFGSUP_PARAMS_SVH
`define CFGSUP_PARAMS_SVH
`define CFGSUP_CFG_WORDS 300
`define CFGSUP_RD_WORDS 500
`define CFGSUP_WR_WORDS 500
`define CFGSUP_OFS_THRESHOLD 0
`define CFGSUP_OFS_PORT_FIRST 1
`define CFGSUP_OFS_PORT_LAST 46
`define CFGSUP_PORT_STRIDE 23
`define CFGSUP_ENABLE_ON 16'h0001
`define CFGSUP_INIT_CYCLES 4
`define CFGSUP_THRESHOLD_RST 16'h0000
`endif

// ==== design/cfgsup_pkg.sv ====
// Purpose: Types for the configuration loader and backplane supervisor
// Assumes: 16-bit host words
// Notes: Constants live in the params header
`default_nettype none
package cfgsup_pkg;
	typedef enum logic [1:0] {
		CFGSUP_WAIT,
		CFGSUP_INIT,
		CFGSUP_RUN,
		CFGSUP_HALT
	} cfgsup_state_t;

	typedef struct packed {
		logic [8:0] offset;
		logic [15:0] data;
	} cfgsup_cfg_word_t;

	typedef struct packed {
		logic [1:0] port;
		logic [8:0] index;
		logic [15:0] data;
	} cfgsup_data_word_t;
endpackage
`default_nettype wire

// ==== design/cfgsup_top.sv ====
// Purpose: Loads start-up configuration and supervises backplane failures
// Assumes: Host delivers configuration words, data words and transfer results
// Notes: Serial framing lies outside; this block gates port traffic only
`timescale 1ns/1ns
`default_nettype none
`include "cfgsup_params.svh"
module cfgsup_top
	import cfgsup_pkg::*;
#(
	parameter int NUM_PORTS = 2,
	parameter int INIT_CYCLES = `CFGSUP_INIT_CYCLES
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic host_boot_in,
	input wire logic debug_boot_in,
	output logic cfg_req_out,
	input wire logic cfg_valid_in,
	input wire cfgsup_cfg_word_t cfg_word_in,
	input wire logic cfg_done_in,
	input wire logic xfer_ok_in,
	input wire logic xfer_fail_in,
	input wire logic wr_valid_in,
	input wire cfgsup_data_word_t wr_word_in,
	output logic wr_ready_out,
	output logic tx_valid_out,
	output cfgsup_data_word_t tx_word_out,
	input wire logic tx_ready_in,
	input wire logic rx_valid_in,
	input wire cfgsup_data_word_t rx_word_in,
	output logic rx_valid_out,
	output cfgsup_data_word_t rx_word_out,
	output logic [NUM_PORTS-1:0] port_enable_out,
	output logic running_out,
	output logic bp_failed_out
);
	if (NUM_PORTS < 1 || NUM_PORTS > 2) begin
		$error("NUM_PORTS must be 1 or 2");
	end
	if (INIT_CYCLES < 1 || INIT_CYCLES > 255) begin
		$error("INIT_CYCLES out of range");
	end
	// Last enable word must stay inside the port parameter area
	if (`CFGSUP_OFS_PORT_FIRST + (NUM_PORTS - 1) * `CFGSUP_PORT_STRIDE >
		`CFGSUP_OFS_PORT_LAST) begin
		$error("Enable offset beyond port area");
	end

	////////////////////////////////////////////////////////////////////
	cfgsup_state_t state_q;
	logic [15:0] threshold_q;
	logic [15:0] fail_cnt_q;
	logic [NUM_PORTS-1:0] port_en_q;
	logic [NUM_PORTS-1:0] port_en_stage_q;
	logic [7:0] init_cnt_q;
	logic boot_req;
	logic active;
	logic limit_hit;

	// Port index of a configuration offset holding an enable word
	function automatic int enable_port(input logic [8:0] ofs);
		int i;
		enable_port = -1;
		for (i = 0; i < NUM_PORTS; i++) begin
			if (ofs == 9'(`CFGSUP_OFS_PORT_FIRST + i * `CFGSUP_PORT_STRIDE))
				enable_port = i;
		end
	endfunction

	// Port exists and is enabled; avoids indexing past NUM_PORTS
	function automatic logic port_on(input logic [1:0] p, input logic [NUM_PORTS-1:0] en);
		port_on = 1'b0;
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (p == 2'(i))
				port_on = en[i];
		end
	endfunction

	assign boot_req = host_boot_in | debug_boot_in;
	assign active = (state_q == CFGSUP_RUN);
	assign limit_hit = (threshold_q != 16'h0000) &&
		({1'b0, fail_cnt_q} + 17'h00001 >= {1'b0, threshold_q});

	////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state_q <= CFGSUP_WAIT;
		end else if (boot_req) begin
			state_q <= CFGSUP_WAIT;
		end else begin
			case (state_q)
				CFGSUP_WAIT: begin
					if (cfg_done_in)
						state_q <= CFGSUP_INIT;
				end
				CFGSUP_INIT: begin
					if (init_cnt_q == 8'(INIT_CYCLES - 1))
						state_q <= CFGSUP_RUN;
				end
				CFGSUP_RUN: begin
					if (xfer_fail_in && !xfer_ok_in && limit_hit)
						state_q <= CFGSUP_HALT;
				end
				CFGSUP_HALT: begin
					if (xfer_ok_in)
						state_q <= CFGSUP_RUN;
				end
				default: state_q <= CFGSUP_WAIT;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in || state_q != CFGSUP_INIT)
			init_cnt_q <= 8'h00;
		else
			init_cnt_q <= init_cnt_q + 8'h01;
	end

	////////////////////////////////////////////////////////////////////
	// Configuration capture, applied only on reload
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			threshold_q <= `CFGSUP_THRESHOLD_RST;
			port_en_stage_q <= '0;
		end else if (state_q == CFGSUP_WAIT && cfg_valid_in) begin
			if (cfg_word_in.offset == 9'(`CFGSUP_OFS_THRESHOLD))
				threshold_q <= cfg_word_in.data;
			for (int i = 0; i < NUM_PORTS; i++) begin
				if (enable_port(cfg_word_in.offset) == i)
					port_en_stage_q[i] <= (cfg_word_in.data == `CFGSUP_ENABLE_ON);
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in || state_q == CFGSUP_WAIT)
			port_en_q <= '0;
		else if (state_q == CFGSUP_INIT)
			port_en_q <= port_en_stage_q;
	end

	////////////////////////////////////////////////////////////////////
	// Successive failure counter
	always_ff @(posedge clk_in) begin
		if (reset_in || state_q == CFGSUP_WAIT || xfer_ok_in)
			fail_cnt_q <= 16'h0000;
		else if (xfer_fail_in && threshold_q != 16'h0000 && fail_cnt_q != 16'hffff)
			fail_cnt_q <= fail_cnt_q + 16'h0001;
	end

	////////////////////////////////////////////////////////////////////
	// Two-entry transmit buffer, write area to ports
	cfgsup_data_word_t buf_q [2];
	logic [1:0] cnt_q;
	logic rd_ptr_q;
	logic wr_ptr_q;
	logic push;
	logic pop;
	logic port_ok;

	assign port_ok = port_on(wr_word_in.port, port_en_q) &&
		wr_word_in.index < 9'(`CFGSUP_WR_WORDS);
	// Discard requests when not running (waiting, init or halted) or for disabled ports or out-of-area indexes; buffer accepts otherwise when not full
	assign wr_ready_out = !active || (cnt_q != 2'd2);
	assign push = wr_valid_in && active && port_ok && (cnt_q != 2'd2);
	assign pop = tx_valid_out && tx_ready_in;
	assign tx_valid_out = active && (cnt_q != 2'd0);
	assign tx_word_out = buf_q[rd_ptr_q];

	always_ff @(posedge clk_in) begin
		if (reset_in || state_q == CFGSUP_WAIT) begin
			cnt_q <= 2'd0;
			rd_ptr_q <= 1'b0;
			wr_ptr_q <= 1'b0;
		end else begin
			cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
			if (push)
				wr_ptr_q <= !wr_ptr_q;
			if (pop)
				rd_ptr_q <= !rd_ptr_q;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			buf_q[0] <= '0;
			buf_q[1] <= '0;
		end else if (push) begin
			buf_q[wr_ptr_q] <= wr_word_in;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Receive path, ports to read area
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rx_valid_out <= 1'b0;
			rx_word_out <= '0;
		end else begin
			rx_valid_out <= rx_valid_in && active && port_on(rx_word_in.port, port_en_q) &&
				rx_word_in.index < 9'(`CFGSUP_RD_WORDS);
			rx_word_out <= rx_word_in;
		end
	end

	assign cfg_req_out = (state_q == CFGSUP_WAIT);
	assign port_enable_out = active ? port_en_q : '0;
	assign running_out = active;
	assign bp_failed_out = (state_q == CFGSUP_HALT);

	////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);

	AST_WAIT_NO_TX: assert property (cfg_req_out |-> !tx_valid_out &&
		port_enable_out == '0 ##1 !rx_valid_out)
		else $error("port traffic while waiting");
	AST_BOOT_RELOAD: assert property (boot_req |=> cfg_req_out && port_enable_out == '0)
		else $error("boot did not force reload");
	AST_DEBUG_BOOT: assert property (debug_boot_in |=> state_q == CFGSUP_WAIT)
		else $error("debug boot ignored");
	AST_ZERO_NO_HALT: assert property (threshold_q == 16'h0000 && active && !boot_req |=> active)
		else $error("halted with zero threshold");
	AST_LIMIT_HALT: assert property (active && xfer_fail_in && !xfer_ok_in && limit_hit
		&& !boot_req |=> bp_failed_out)
		else $error("threshold reached without halt");
	AST_RESUME: assert property (bp_failed_out && xfer_ok_in && !boot_req |=> running_out)
		else $error("no resume after success");
	AST_CNT_CLEAR: assert property (xfer_ok_in |=> fail_cnt_q == 16'h0000)
		else $error("counter not cleared");
	AST_HALT_DISCARD: assert property (bp_failed_out |-> !tx_valid_out && wr_ready_out
		##1 $stable(cnt_q))
		else $error("traffic while halted");
	AST_INIT_LEN: assert property (disable iff (reset_in || boot_req)
		$rose(state_q == CFGSUP_INIT) |-> !running_out ##INIT_CYCLES running_out)
		else $error("init length wrong");
	AST_DISABLED_PORT: assert property (tx_valid_out |->
		port_on(tx_word_out.port, port_enable_out))
		else $error("disabled port sent data");

	COV_RUN: cover property (state_q == CFGSUP_INIT ##[1:8] running_out);
	COV_HALT: cover property (running_out ##1 bp_failed_out);
	COV_RESUME: cover property (bp_failed_out ##1 running_out);
	COV_FULL: cover property (cnt_q == 2'd2 ##1 pop);
endmodule
`default_nettype wire

// ==== tb/cfgsup_host_model.sv ====
// Purpose: Host-side model answering configuration requests
// Assumes: Design asks by holding cfg_req_in high
// Notes: Sends threshold, two port enables, then the end strobe
`timescale 1ns/1ns
`default_nettype none
`include "cfgsup_params.svh"
module cfgsup_host_model
	import cfgsup_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic cfg_req_in,
	input wire logic [15:0] thr_in,
	input wire logic [15:0] en0_in,
	input wire logic [15:0] en1_in,
	output logic cfg_valid_out,
	output cfgsup_cfg_word_t cfg_word_out,
	output logic cfg_done_out
);
	logic [2:0] step_q;
	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_in) begin
		cfg_valid_out <= 1'b0;
		cfg_done_out <= 1'b0;
		cfg_word_out <= ~cfg_word_out;
		if (reset_in) begin
			step_q <= 3'h0;
			cfg_word_out <= '0;
		end else if (step_q == 3'h0) begin
			step_q <= {2'h0, cfg_req_in};
		end else if (step_q < 3'h4) begin
			cfg_valid_out <= 1'b1;
			case (step_q)
				3'h1: cfg_word_out <= {9'(`CFGSUP_OFS_THRESHOLD), thr_in};
				3'h2: cfg_word_out <= {9'(`CFGSUP_OFS_PORT_FIRST), en0_in};
				default: cfg_word_out <= {9'(`CFGSUP_OFS_PORT_FIRST + `CFGSUP_PORT_STRIDE), en1_in};
			endcase
			step_q <= step_q + 3'h1;
		end else if (step_q == 3'h4) begin
			cfg_done_out <= 1'b1;
			step_q <= 3'h5;
		end else if (!cfg_req_in) begin
			step_q <= 3'h0;
		end
	end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the loader and supervisor
// Assumes: Default port count and init length
// Notes: Host model supplies configuration on every request
`timescale 1ns/1ns
`default_nettype none
`include "cfgsup_params.svh"
module tb_top
	import cfgsup_pkg::*;
;
	logic clk_in = 0, reset_in = 1, host_boot_in = 0, debug_boot_in = 0, cfg_req_out;
	logic cfg_valid_in, cfg_done_in, xfer_ok_in = 0, xfer_fail_in = 0, wr_valid_in = 0;
	logic wr_ready_out, tx_valid_out, tx_ready_in = 0, rx_valid_in = 0, rx_valid_out;
	logic running_out, bp_failed_out;
	logic [1:0] port_enable_out;
	logic [15:0] thr = 16'h0003, en0 = 16'h0001, en1 = 16'h0000;
	cfgsup_cfg_word_t cfg_word_in;
	cfgsup_data_word_t wr_word_in = '0, tx_word_out, rx_word_in = '0, rx_word_out;
	int n_mismatch = 0, checks = 0, cycles = 0;
	cfgsup_host_model host (.clk_in, .reset_in, .cfg_req_in(cfg_req_out), .thr_in(thr),
		.en0_in(en0), .en1_in(en1), .cfg_valid_out(cfg_valid_in), .cfg_word_out(cfg_word_in),
		.cfg_done_out(cfg_done_in));
	cfgsup_top #(.NUM_PORTS(2)) DUT (.clk_in, .reset_in, .host_boot_in, .debug_boot_in,
		.cfg_req_out, .cfg_valid_in, .cfg_word_in, .cfg_done_in, .xfer_ok_in, .xfer_fail_in,
		.wr_valid_in, .wr_word_in, .wr_ready_out, .tx_valid_out, .tx_word_out, .tx_ready_in,
		.rx_valid_in, .rx_word_in, .rx_valid_out, .rx_word_out, .port_enable_out,
		.running_out, .bp_failed_out);
	////////////////////////////////////////////////////////////////
	initial begin
		forever #20 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			close_out();
		end
	end
	task automatic close_out();
		if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input cfgsup_data_word_t w);
		@(posedge clk_in);
		wr_valid_in <= 1'b1;
		wr_word_in <= w;
		do @(posedge clk_in); while (wr_ready_out !== 1'b1);
		wr_valid_in <= 1'b0;
		#1;
	endtask
	task automatic xf(input logic ok, input int n);
		repeat (n) begin
			@(posedge clk_in);
			xfer_ok_in <= ok;
			xfer_fail_in <= !ok;
			@(posedge clk_in);
			xfer_ok_in <= 1'b0;
			xfer_fail_in <= 1'b0;
		end
		#1;
	endtask
	task automatic rx(input cfgsup_data_word_t w, input logic v);
		@(posedge clk_in);
		rx_valid_in <= 1'b1;
		rx_word_in <= w;
		@(posedge clk_in) rx_valid_in <= 1'b0;
		#1 chk(rx_valid_out, v);
		if (v)
			chk(rx_word_out, w);
	endtask
	task automatic wait_run(input logic [1:0] en);
		for (int i = 0; i < 40 && running_out !== 1'b1; i++) @(posedge clk_in) #1;
		chk(running_out, 1'b1);
		chk(port_enable_out, en);
		chk(tx_valid_out, 1'b0);
	endtask
	task automatic t_wait();
		wr({2'h0, 9'h005, 16'ha5a5});
		chk(tx_valid_out, 1'b0);
		chk(running_out, 1'b0);
		wait_run(2'h1);
	endtask
	task automatic t_data();
		wr({2'h0, 9'h001, 16'h1234});
		wr({2'h0, 9'h002, 16'hbeef});
		chk(wr_ready_out, 1'b0);
		chk(tx_word_out, {2'h0, 9'h001, 16'h1234});
		xf(1'b1, 0);
		@(posedge clk_in) tx_ready_in <= 1'b1;
		@(posedge clk_in) tx_ready_in <= 1'b0;
		#1 chk(tx_word_out, {2'h0, 9'h002, 16'hbeef});
		@(posedge clk_in) tx_ready_in <= 1'b1;
		wr({2'h1, 9'h003, 16'h7777});
		#1 chk(tx_valid_out, 1'b0);
		wr({2'h0, 9'(`CFGSUP_WR_WORDS), 16'h5555});
		#1 chk(tx_valid_out, 1'b0);
		rx({2'h0, 9'h00a, 16'hc3c3}, 1'b1);
		rx({2'h1, 9'h00b, 16'h3c3c}, 1'b0);
		rx({2'h0, 9'(`CFGSUP_RD_WORDS), 16'h5a5a}, 1'b0);
	endtask
	task automatic t_fail();
		xf(1'b0, 2);
		chk(bp_failed_out, 1'b0);
		xf(1'b0, 1);
		chk({bp_failed_out, running_out}, 2'h2);
		wr({2'h0, 9'h004, 16'h0f0f});
		chk(tx_valid_out, 1'b0);
		xf(1'b1, 1);
		chk({bp_failed_out, running_out}, 2'h1);
		chk(tx_valid_out, 1'b0);
		xf(1'b0, 2);
		xf(1'b1, 1);
		xf(1'b0, 2);
		chk(bp_failed_out, 1'b0);
	endtask
	task automatic boot(input logic dbg, input logic [15:0] t, input logic [15:0] e1,
		input logic [1:0] en);
		thr <= t;
		en1 <= e1;
		@(posedge clk_in);
		debug_boot_in <= dbg;
		host_boot_in <= !dbg;
		@(posedge clk_in);
		{debug_boot_in, host_boot_in} <= 2'h0;
		#1 chk({cfg_req_out, running_out}, 2'h2);
		wait_run(en);
	endtask
	task automatic t_reset();
		@(posedge clk_in) reset_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		#1 chk({cfg_req_out, running_out, bp_failed_out, tx_valid_out, rx_valid_out,
			port_enable_out}, 7'h40);
		@(posedge clk_in) reset_in <= 1'b0;
		wait_run(2'h1);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk_in);
		reset_in <= 1'b0;
		t_wait();
		t_data();
		t_fail();
		boot(1'b1, 16'h0000, 16'h0001, 2'h3);
		xf(1'b0, 5);
		chk({bp_failed_out, running_out}, 2'h1);
		boot(1'b0, 16'h0003, 16'h0000, 2'h1);
		t_reset();
		close_out();
	end
endmodule
`default_nettype wire
